// ==== inc/hlt_timer_pkg.sv ====
`default_nettype none
package hlt_timer_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int          ADDR_W   = 16;
    localparam int          DATA_W   = 32;
    localparam int          REG_W    = 8;
    localparam int          SEL_W    = 4;
    localparam int          NUM_SRC  = 16;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_COUNT  = 12'hFBA;
    localparam logic [11:0] IDX_PERIOD = 12'hFBB;
    localparam logic [11:0] IDX_CON    = 12'hFBC;
    localparam logic [11:0] IDX_HLT    = 12'hFBD;
    localparam logic [11:0] IDX_CLKSEL = 12'hFBE;
    localparam logic [11:0] IDX_RSTSRC = 12'hFBF;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          ON_BIT     = 7;
    localparam int          CLOCK_PRESCALE_SELECT_LSB   = 4;
    localparam int          CLOCK_PRESCALE_SELECT_W     = 3;
    localparam int          OUTPUT_POSTSCALE_SELECT_LSB  = 0;
    localparam int          OUTPUT_POSTSCALE_SELECT_W    = 4;
    localparam int          PRESCALER_SYNC_ENABLE_BIT  = 7;
    localparam int          CLOCK_EDGE_POLARITY_BIT   = 6;
    localparam int          ENABLE_SYNC_TO_TIMER_CLOCK_BIT  = 5;
    localparam int          MODE_LSB   = 0;
    localparam int          MODE_W     = 5;
    localparam int          PRE_CNT_W  = 7;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  COUNT_RST  = 8'h00;
    localparam logic [7:0]  PERIOD_RST = 8'hFF;
    localparam logic [7:0]  CON_RST    = 8'h00;
    localparam logic [7:0]  HLT_RST    = 8'h00;
    localparam logic [3:0]  CLKSEL_RST = 4'h0;
    localparam logic [3:0]  RSTSRC_RST = 4'h0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [1:0]  FOSC4_LAST = 2'h3;

    // ****************************************************************
    // modes with hardware-limit behaviour
    // ****************************************************************
    localparam logic [4:0]  MODE_MONO_RISE  = 5'h11;
    localparam logic [4:0]  MODE_MONO_FALL  = 5'h12;
    localparam logic [4:0]  MODE_MONO_BOTH  = 5'h13;
    localparam logic [4:0]  MODE_SHOT_LOW   = 5'h16;
    localparam logic [4:0]  MODE_SHOT_HIGH  = 5'h17;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b11
    } run_state_e;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

endpackage
`default_nettype wire

// ==== rtl/hlt_sync2.sv ====
`timescale 1ns/1ns
`default_nettype none
module hlt_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // hlt_sync2
`default_nettype wire

// ==== rtl/hlt_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
module hlt_prescaler (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            clear,
    input  wire logic                            tick,
    input  wire logic [hlt_timer_pkg::CLOCK_PRESCALE_SELECT_W-1:0] ratio_sel,
    output logic                                 out_pulse
);
    import hlt_timer_pkg::*;
    logic [PRE_CNT_W-1:0] cnt_q;
    logic [PRE_CNT_W-1:0] cnt_d;
    logic [PRE_CNT_W-1:0] last;

    // power-of-two ratio: 1:1 at code 0, 1:128 at code 7
    assign last      = PRE_CNT_W'((8'h01 << ratio_sel) - 8'h01);
    assign out_pulse = tick && (cnt_q == last);

    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = out_pulse ? '0 : cnt_q + PRE_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    property p_pre_ratio;
        @(posedge pclk) disable iff (!presetn)
        (tick && !clear && ratio_sel == 3'h1 && cnt_q == 7'h0) |-> !out_pulse;
    endproperty
    a_pre_ratio: assert property (p_pre_ratio) else $error("prescaler pulsed early");
endmodule // hlt_prescaler
`default_nettype wire

// ==== rtl/hw_limit_timer_control.sv ====
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module hw_limit_timer_control (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [hlt_timer_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [hlt_timer_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic      [hlt_timer_pkg::DATA_W-1:0]   prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic [hlt_timer_pkg::NUM_SRC-1:0]  clk_src_in,
    input  wire logic [hlt_timer_pkg::NUM_SRC-1:0]  ext_reset_in,
    input  wire logic                              cpu_sleep,
    output logic                                   timer_event,
    output logic                                   period_match,
    output logic                                   timer_running
);
    import hlt_timer_pkg::*;

    // ****************************************************************
    // register bus
    // ****************************************************************
    logic [REG_W-1:0]  count_q, count_d;
    logic [REG_W-1:0]  period_q, period_d;
    logic [REG_W-1:0]  con_q, con_d;
    logic [REG_W-1:0]  hlt_q, hlt_d;
    logic [SEL_W-1:0]  clksel_q, clksel_d;
    logic [SEL_W-1:0]  rstsrc_q, rstsrc_d;
    logic [DATA_W-1:0] prdata_d;
    logic              pready_d, pslverr_d;
    logic              access, commit, wr_ok, hit;
    logic [REG_W-1:0]  rd_val;
    logic              hw_clear_on;
    assign access = psel && penable;
    assign commit = access && pready;
    assign wr_ok  = commit && pwrite && pstrb[0] && hit;
    always_comb begin
        hit    = 1'b1;
        rd_val = '0;
        unique case (paddr)
            byte_addr(IDX_COUNT):  rd_val = count_q;
            byte_addr(IDX_PERIOD): rd_val = period_q;
            byte_addr(IDX_CON):    rd_val = con_q;
            byte_addr(IDX_HLT):    rd_val = hlt_q;
            byte_addr(IDX_CLKSEL): rd_val = {4'h0, clksel_q};
            byte_addr(IDX_RSTSRC): rd_val = {4'h0, rstsrc_q};
            default:               hit = 1'b0;
        endcase
    end

    // one wait state: answer lands on the second access cycle
    always_comb begin
        pready_d  = access && !pready;
        pslverr_d = pready_d && !hit;
        prdata_d  = prdata;
        if (pready_d) begin
            prdata_d = (hit && !pwrite) ? {24'h0, rd_val} : '0;
        end
    end

    always_comb begin
        period_d = period_q;
        hlt_d    = hlt_q;
        clksel_d = clksel_q;
        rstsrc_d = rstsrc_q;
        con_d    = con_q;
        if (hw_clear_on) begin
            con_d[ON_BIT] = 1'b0;
        end
        if (wr_ok) begin
            unique case (paddr)
                byte_addr(IDX_PERIOD): period_d = pwdata[REG_W-1:0];
                byte_addr(IDX_CON):    con_d    = pwdata[REG_W-1:0];
                byte_addr(IDX_HLT):    hlt_d    = pwdata[REG_W-1:0];
                byte_addr(IDX_CLKSEL): clksel_d = pwdata[SEL_W-1:0];
                byte_addr(IDX_RSTSRC): rstsrc_d = pwdata[SEL_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_q <= PERIOD_RST;
            con_q    <= CON_RST;
            hlt_q    <= HLT_RST;
            clksel_q <= CLKSEL_RST;
            rstsrc_q <= RSTSRC_RST;
            prdata   <= '0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            period_q <= period_d;
            con_q    <= con_d;
            hlt_q    <= hlt_d;
            clksel_q <= clksel_d;
            rstsrc_q <= rstsrc_d;
            prdata   <= prdata_d;
            pready   <= pready_d;
            pslverr  <= pslverr_d;
        end
    end

    // ****************************************************************
    // input clock and reset source selection
    // ****************************************************************
    logic [2*NUM_SRC-1:0] pins_s;
    logic                 clk_lvl, clk_prev_q, ext_lvl, ext_prev_q;
    logic                 in_tick, ext_rise, ext_fall;
    logic                 on_bit, prescaler_sync_enable, clock_edge_polarity, enable_sync_to_timer_clock;
    logic [MODE_W-1:0]    mode;
    hlt_sync2 #(.WIDTH(2*NUM_SRC)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({ext_reset_in, clk_src_in}),
        .sync_out (pins_s)
    );
    assign on_bit  = con_q[ON_BIT];
    assign prescaler_sync_enable   = hlt_q[PRESCALER_SYNC_ENABLE_BIT];
    assign clock_edge_polarity    = hlt_q[CLOCK_EDGE_POLARITY_BIT];
    assign enable_sync_to_timer_clock   = hlt_q[ENABLE_SYNC_TO_TIMER_CLOCK_BIT];
    assign mode    = hlt_q[MODE_LSB +: MODE_W];
    assign clk_lvl = pins_s[clksel_q];
    assign ext_lvl = pins_s[NUM_SRC + int'(rstsrc_q)];
    // flipping polarity while on cannot fake an edge here: both terms need the level to change
    assign in_tick  = clock_edge_polarity ? (clk_prev_q && !clk_lvl) : (!clk_prev_q && clk_lvl);
    assign ext_rise = !ext_prev_q && ext_lvl;
    assign ext_fall = ext_prev_q && !ext_lvl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_lvl;
            ext_prev_q <= ext_lvl;
        end
    end

    // ****************************************************************
    // enable retiming, run state, instruction clock
    // ****************************************************************
    logic [1:0]  en_pipe_q, en_pipe_d;
    logic [1:0]  div_q, div_d;
    logic        on_eff, fosc4_tick, run, sleep_block, tmr_tick;
    logic        mono, shot, shot_hold, start_edge, match;
    run_state_e  state_q, state_d;
    assign fosc4_tick  = (div_q == FOSC4_LAST);
    assign div_d       = div_q + 2'h1;
    // retiming only delays the start; clearing the enable stops at once
    assign on_eff      = on_bit && (!enable_sync_to_timer_clock || en_pipe_q[1]);
    assign sleep_block = prescaler_sync_enable && cpu_sleep;
    assign run         = (state_q == ST_RUN) && on_eff && !sleep_block;
    assign mono        = (mode == MODE_MONO_RISE) || (mode == MODE_MONO_FALL) || (mode == MODE_MONO_BOTH);
    assign shot        = (mode == MODE_SHOT_LOW) || (mode == MODE_SHOT_HIGH);
    assign shot_hold   = shot && (ext_lvl == (mode == MODE_SHOT_HIGH));
    assign start_edge  = ((mode != MODE_MONO_FALL) && ext_rise) || ((mode != MODE_MONO_RISE) && ext_fall);
    always_comb begin
        en_pipe_d = en_pipe_q;
        if (!on_bit) begin
            en_pipe_d = '0;
        end else if (in_tick) begin
            en_pipe_d = {en_pipe_q[0], 1'b1};
        end
    end

    always_comb begin
        state_d = state_q;
        if (!on_eff) begin
            state_d = ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: state_d = (mono || shot_hold) ? ST_WAIT : ST_RUN;
                ST_WAIT: begin
                    if (mono ? start_edge : !shot_hold) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (shot_hold) begin
                        state_d = ST_WAIT;
                    end else if (mono && tmr_tick && match) begin
                        state_d = ST_WAIT;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_pipe_q <= '0;
            div_q     <= '0;
            state_q   <= ST_IDLE;
        end else begin
            en_pipe_q <= en_pipe_d;
            div_q     <= div_d;
            state_q   <= state_d;
        end
    end

    // ****************************************************************
    // prescaler, instruction clock alignment, counter, postscaler
    // ****************************************************************
    logic               pre_out, pend_q, pend_d, event_d;
    logic [OUTPUT_POSTSCALE_SELECT_W-1:0] post_q, post_d;
    hlt_prescaler u_pre (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (!run),
        .tick      (in_tick && run),
        .ratio_sel (con_q[CLOCK_PRESCALE_SELECT_LSB +: CLOCK_PRESCALE_SELECT_W]),
        .out_pulse (pre_out)
    );
    // aligned ticks keep a software read of the count coherent
    assign tmr_tick    = prescaler_sync_enable ? ((pend_q || pre_out) && fosc4_tick && run) : pre_out;
    assign pend_d      = prescaler_sync_enable && run && (pend_q || pre_out) && !fosc4_tick;
    assign match       = (count_q == period_q);
    assign hw_clear_on = shot && tmr_tick && match;

    always_comb begin
        count_d = count_q;
        if (wr_ok && paddr == byte_addr(IDX_COUNT)) begin
            count_d = pwdata[REG_W-1:0];
        end else if (shot_hold && on_eff) begin
            count_d = COUNT_RST;
        end else if (tmr_tick) begin
            count_d = match ? COUNT_RST : count_q + 8'h01;
        end
    end

    always_comb begin
        post_d  = post_q;
        event_d = 1'b0;
        if (!on_eff) begin
            post_d = '0;
        end else if (tmr_tick && match) begin
            event_d = (post_q == con_q[OUTPUT_POSTSCALE_SELECT_LSB +: OUTPUT_POSTSCALE_SELECT_W]);
            post_d  = event_d ? '0 : post_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q       <= COUNT_RST;
            pend_q        <= 1'b0;
            post_q        <= '0;
            timer_event   <= 1'b0;
            period_match  <= 1'b0;
            timer_running <= 1'b0;
        end else begin
            count_q       <= count_d;
            pend_q        <= pend_d;
            post_q        <= post_d;
            timer_event   <= event_d;
            period_match  <= tmr_tick && match;
            timer_running <= run;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_on_rise;
        !on_bit ##1 on_bit;
    endsequence
    sequence s_no_start_2;
        !en_pipe_q[1] [*2];
    endsequence
    property p_off_reset;
        !on_bit |=> (post_q == 4'h0) && (en_pipe_q == 2'h0) && !run;
    endproperty
    a_off_reset: assert property (p_off_reset) else $error("state not held in reset while off");
    property p_hw_clear;
        hw_clear_on && !wr_ok |=> !on_bit;
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("one-shot match did not clear enable");
    property p_post;
        event_d |-> post_q == con_q[3:0] && tmr_tick && match;
    endproperty
    a_post: assert property (p_post) else $error("postscaler fired on wrong match");
    property p_prescaler_sync_enable;
        prescaler_sync_enable && tmr_tick |-> fosc4_tick;
    endproperty
    a_prescaler_sync_enable: assert property (p_prescaler_sync_enable) else $error("tick not aligned to instruction clock");
    property p_sleep;
        prescaler_sync_enable && cpu_sleep |-> !tmr_tick && !run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("timer ran in sleep with prescaler sync");
    property p_enable_sync_to_timer_clock_delay;
        enable_sync_to_timer_clock && !on_bit ##1 (enable_sync_to_timer_clock && on_bit) |-> s_no_start_2;
    endproperty
    a_enable_sync_to_timer_clock_delay: assert property (p_enable_sync_to_timer_clock_delay) else $error("enable passed too early");
    property p_enable_sync_to_timer_clock_seq;
        enable_sync_to_timer_clock && $rose(en_pipe_q[1]) |-> $past(en_pipe_q[0]) && $past(in_tick);
    endproperty
    a_enable_sync_to_timer_clock_seq: assert property (p_enable_sync_to_timer_clock_seq) else $error("enable not retimed to input clock");
    property p_wrap;
        tmr_tick && match && !(wr_ok && paddr == byte_addr(IDX_COUNT)) |=> count_q == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not clear after period match");
    property p_hold;
        !on_bit && !wr_ok |=> $stable(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("count changed while stopped");
    property p_start;
        s_on_rise ##0 (!enable_sync_to_timer_clock && !mono && !shot) |=> state_q == ST_RUN || !on_bit;
    endproperty
    a_start: assert property (p_start) else $error("free mode did not start on enable");
endmodule // hw_limit_timer_control
`default_nettype wire

// ==== tb/hlt_src_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// far-side clock and reset sources
// ****************************************************************
module hlt_src_model #(
    parameter int HALF = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [3:0]  clk_idx,
    input  wire logic [9:0]  n_tog,
    input  wire logic [3:0]  rst_idx,
    input  wire logic        rst_lvl,
    output logic      [15:0] clk_src_in,
    output logic      [15:0] ext_reset_in,
    output logic             busy
);
    logic [9:0] left_q;
    int         div_q;

    // clocks stand still between bursts; each level lasts HALF cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_src_in <= 16'h0000;
            left_q     <= 10'h000;
            div_q      <= 0;
            busy       <= 1'b0;
        end else if (start && !busy) begin
            left_q <= n_tog;
            div_q  <= 0;
            busy   <= 1'b1;
        end else if (busy) begin
            if (left_q == 10'h000) begin
                busy <= 1'b0;
            end else if (div_q == HALF - 1) begin
                div_q               <= 0;
                clk_src_in[clk_idx] <= ~clk_src_in[clk_idx];
                left_q              <= left_q - 10'h001;
            end else begin
                div_q <= div_q + 1;
            end
        end
    end

    assign ext_reset_in = rst_lvl ? (16'h0001 << rst_idx) : 16'h0000;
endmodule // hlt_src_model
`default_nettype wire

// ==== tb/hw_limit_timer_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module hw_limit_timer_control_tb;
    import hlt_timer_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic              cpu_sleep = 1'b0;
    logic              start = 1'b0;
    logic              rst_lvl = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rq;
    logic              pready, pslverr, er, timer_event, period_match, timer_running, busy;
    logic [15:0]       clk_src_in, ext_reset_in;
    logic [3:0]        cidx = 4'h0;
    logic [3:0]        ridx = 4'h0;
    logic [9:0]        n_tog = 10'h000;
    int                err_total = 0;
    int                checks = 0;
    int                pm_n = 0;
    int                ev_n = 0;
    int                m_cnt, m_pm;
    int                lvl[16];
    int                pst[3] = '{0, 2, 15};

    always #2 pclk = ~pclk;

    hw_limit_timer_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_src_in(clk_src_in), .ext_reset_in(ext_reset_in),
        .cpu_sleep(cpu_sleep), .timer_event(timer_event), .period_match(period_match),
        .timer_running(timer_running));

    hlt_src_model src (.pclk(pclk), .presetn(presetn), .start(start), .clk_idx(cidx), .n_tog(n_tog),
        .rst_idx(ridx), .rst_lvl(rst_lvl), .clk_src_in(clk_src_in), .ext_reset_in(ext_reset_in),
        .busy(busy));

    // pulses last one cycle, so the falling edge sees each once
    always @(negedge pclk) begin
        if (period_match === 1'b1) pm_n++;
        if (timer_event === 1'b1) ev_n++;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bound(input int k, input int lim);
        if (k >= lim) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // pready is looked at on the rising edge; write lands and data is taken there
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        bound(n, 16);
        rq = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp, input string nm);
        apb(1'b0, idx, 8'h00);
        check(nm, {24'h000000, exp}, rq);
    endtask

    // behavioural counter: restart after count equals period
    task automatic madv(input int ticks, input int per);
        for (int i = 0; i < ticks; i++) begin
            if (m_cnt == per) begin
                m_cnt = 0;
                m_pm++;
            end else m_cnt++;
        end
    endtask

    task automatic go(input int con, input int hlt, input int per, input int n, input int sk);
        int c, k, e;
        c = $urandom_range(15, 0);
        k = 0;
        cidx <= c;
        apb(1'b1, IDX_CLKSEL, c);
        apb(1'b1, IDX_HLT, hlt);
        apb(1'b1, IDX_PERIOD, per);
        apb(1'b1, IDX_COUNT, 8'h00);
        m_cnt = 0;
        m_pm  = 0;
        pm_n  = 0;
        ev_n  = 0;
        apb(1'b1, IDX_CON, con | 8'h80);
        @(posedge pclk);
        n_tog <= n;
        start <= 1'b1;
        do begin @(negedge pclk); k++; end while (busy !== 1'b1 && k < 8);
        bound(k, 8);
        @(posedge pclk);
        start <= 1'b0;
        k = 0;
        do begin @(negedge pclk); k++; end while (busy !== 1'b0 && k < 9000);
        bound(k, 9000);
        repeat (12) @(posedge pclk);
        e = (lvl[c] != 0) ? n / 2 : (n + 1) / 2;
        if (hlt[6]) e = n - e;
        lvl[c] = lvl[c] ^ (n & 1);
        e = (e >> ((con >> 4) & 7)) - sk;
        madv((e < 0) ? 0 : e, per);
    endtask

    task automatic fin(input string nm, input logic run_exp);
        check("running", run_exp, timer_running);
        apb(1'b1, IDX_CON, 8'h00);
        rchk(IDX_COUNT, m_cnt, nm);
        check("matches", m_pm, pm_n);
        $display("test %s done", nm);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h6DB3));
        for (int i = 0; i < 16; i++) lvl[i] = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(IDX_COUNT, COUNT_RST, "count rst");
        rchk(IDX_PERIOD, 8'hFF, "period rst");
        rchk(IDX_CON, 8'h00, "control rst");
        rchk(IDX_HLT, 8'h00, "limit rst");
        apb(1'b1, IDX_CLKSEL, 8'hF9);
        rchk(IDX_CLKSEL, 8'h09, "clock select");
        apb(1'b1, IDX_RSTSRC, 8'hA6);
        rchk(IDX_RSTSRC, 8'h06, "reset source");
        rchk(12'h010, 8'h00, "unmapped data");
        check("unmapped err", 1'b1, er);
        $display("test registers done");
        for (int ps = 0; ps < 8; ps++) begin
            go(ps << 4, 8'h00, $urandom_range(255, 0), 4 << ps, 0);
            fin("prescale", 1'b1);
        end
        go(8'h00, 8'h40, 8'hFF, 7, 0);
        fin("falling edge", 1'b1);
        go(8'h00, 8'h00, 8'hFF, 7, 0);
        fin("rising edge", 1'b1);
        foreach (pst[j]) begin
            go(pst[j], 8'h05, 3, 128, 0);
            fin("postscale", 1'b1);
            check("events", 16 / (pst[j] + 1), ev_n);
        end
        go(8'h00, 8'h20, 8'hFF, 10, 2);
        fin("enable sync", 1'b1);
        cpu_sleep <= 1'b1;
        go(8'h00, 8'h80, 8'hFF, 8, 99);
        fin("sleep sync", 1'b0);
        go(8'h00, 8'h00, 8'hFF, 8, 0);
        fin("sleep free", 1'b1);
        cpu_sleep <= 1'b0;
        go(8'h00, 8'h80, 8'hFF, 8, 0);
        fin("awake sync", 1'b1);
        ridx    <= $urandom_range(15, 0);
        rst_lvl <= 1'b1;
        @(posedge pclk);
        apb(1'b1, IDX_RSTSRC, ridx);
        go(8'h00, MODE_SHOT_LOW, 2, 12, 0);
        m_cnt = 0;
        m_pm  = 1;
        rchk(IDX_CON, 8'h00, "hw clear");
        fin("one shot", 1'b0);
        go(8'h00, MODE_SHOT_HIGH, 2, 12, 99);
        rchk(IDX_CON, 8'h80, "level hold");
        fin("hold high", 1'b0);
        rst_lvl <= 1'b0;
        go(8'h00, MODE_MONO_RISE, 8'hFF, 8, 99);
        fin("edge wait", 1'b0);
        end_sim();
    end
endmodule // hw_limit_timer_control_tb
`default_nettype wire
